// ===== src/dcc_pkg.sv
package dcc_pkg;
   // ------------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------------
   localparam logic [11:0] ADDR_GCTRL   = 12'h000; // convert requests
   localparam logic [11:0] ADDR_GSTAT   = 12'h004; // busy flags
   localparam logic [11:0] ADDR_MODE0   = 12'h010; // per-device mode
   localparam logic [11:0] ADDR_CFG0    = 12'h020; // per-channel config
   localparam logic [11:0] ADDR_DATA0   = 12'h060; // per-channel data
   localparam logic [11:0] ADDR_GAIN0   = 12'h0A0; // per-channel gain
   localparam logic [11:0] ADDR_OFFS0   = 12'h0E0; // per-channel offset
   // ------------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------------
   localparam int MODE_SEQ_BIT   = 0;   // 1: sequencer mode
   localparam int MODE_CTRL_BIT  = 1;   // 1: manual controlled
   localparam int CFG_RANGE_LSB  = 0;   // 4-bit range code
   localparam int CFG_PWR_BIT    = 4;   // 1: powered up
   localparam int CFG_OEN_BIT    = 5;   // 1: output enabled
   localparam logic [5:0] CFG_RESET  = 6'h00;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // range codes: 0-3 unipolar, 4-7 bipolar, 8-10 current
   localparam logic [3:0] RANGE_BIP_LO = 4'h4;
   localparam logic [3:0] RANGE_BIP_HI = 4'h7;
   localparam logic [3:0] RANGE_LAST   = 4'hA;
   // ------------------------------------------------------------------
   // correction scaling
   // ------------------------------------------------------------------
   localparam int GAIN_SHIFT = 18; // divide by 262144
   localparam int OFFS_SHIFT = 2;  // divide by 4
   // serial word: 2 kind bits, 3 channel bits, pad, 16 data or 6 config payload bits
   localparam int WORD_W     = 24;
   localparam logic [1:0] KIND_DATA = 2'h1;
   localparam logic [1:0] KIND_CFG  = 2'h2;
   // load strobe low time, ns, and derived cycles at 10 MHz
   localparam int LOAD_NS       = 200;
   localparam int CLK_NS        = 100;
   localparam int LOAD_CYCLES   = (LOAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCLK_DIV      = 2; // serial bit every 2 cycles
endpackage : dcc_pkg

// ===== src/dcc_ser_if.sv
// transfer request channel between controller and serialiser
interface dcc_ser_if;
   logic                     valid;
   logic                     ready;
   logic [dcc_pkg::WORD_W-1:0] word;
   modport ctl (output valid, output word, input ready);
   modport ser (input valid, input word, output ready);
endinterface : dcc_ser_if

// ===== src/dcc_serializer.sv
module dcc_serializer (
   input  wire logic pclk,
   input  wire logic presetn,
   dcc_ser_if.ser    req,
   output logic      sclk_q,
   output logic      sdo_q,
   output logic      sync_n_q
);
   localparam int CW = $clog2(dcc_pkg::WORD_W + 1);
   logic [dcc_pkg::WORD_W-1:0] sh_q;
   logic [CW-1:0]              cnt_q;
   logic                       div_q;
   logic                       act_q;

   // ready only while idle, so one word at a time
   assign req.ready = !act_q;

   // shift word out msb first, one bit per divider enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q     <= '0;
         cnt_q    <= '0;
         div_q    <= 1'b0;
         act_q    <= 1'b0;
         sclk_q   <= 1'b0;
         sdo_q    <= 1'b0;
         sync_n_q <= 1'b1;
      end else if (!act_q) begin
         sclk_q <= 1'b0;
         if (req.valid) begin
            sh_q     <= req.word;
            cnt_q    <= CW'(dcc_pkg::WORD_W);
            act_q    <= 1'b1;
            div_q    <= 1'b0;
            sync_n_q <= 1'b0;
         end
      end else begin
         div_q <= !div_q;
         if (!div_q) begin
            // falling half: present next bit
            sclk_q <= 1'b0;
            if (cnt_q == '0) begin
               act_q    <= 1'b0;
               sync_n_q <= 1'b1;
            end else begin
               sdo_q <= sh_q[dcc_pkg::WORD_W-1];
               sh_q  <= {sh_q[dcc_pkg::WORD_W-2:0], 1'b0};
               cnt_q <= cnt_q - CW'(1);
            end
         end else begin
            sclk_q <= 1'b1; // rising half: far side samples sdo here
         end
      end
   end
endmodule : dcc_serializer

// ===== src/dcc_top.sv
// ---------------------------------------------------------------------
// Summary of operation
// - each device has four 16-bit channels
// - one or two devices by parameter
// - eleven selectable ranges per channel
// - unipolar data is straight binary
// - bipolar data is two's complement
// - current ranges straight binary, offset 4mA
// - correct by gain/262144 then offset/4
// - corrections are signed 16-bit; offset in quarter steps
// - zero corrections pass data unchanged
// - immediate mode write transfers then loads
// - reset gives immediate mode, channels off
// - per-device manual or sequencer mode
// - sequencer clock converts all sequencer devices
// - controlled mode updates on command bit
// - immediate load only after busy clears
// - busy flag per device in status
// - convert request bit loads at once in controlled mode
// - sequencer clock from rear input line
// ---------------------------------------------------------------------
//
// The register offsets and the APB interface to the registers are this design's own decisions.
module dcc_top #(
   parameter int NUM_DEV = 2
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                seq_conv_clk,
   output logic [NUM_DEV-1:0]       dac_sclk,
   output logic [NUM_DEV-1:0]       dac_sdo,
   output logic [NUM_DEV-1:0]       dac_sync_n,
   output logic [NUM_DEV-1:0]       converter_load_strobe_n
);
   localparam int NCH = 4 * NUM_DEV;

   // ------------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------------
   if (NUM_DEV != 1 && NUM_DEV != 2) begin : g_bad
      $error("NUM_DEV must be 1 or 2");
   end

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   logic        wr_en;
   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1; // zero wait states, fixed latency

   // per-channel and per-device storage
   logic [5:0]  cfg_q   [NCH];
   logic [15:0] data_q  [NCH];
   logic [15:0] gain_q  [NCH];
   logic [15:0] offs_q  [NCH];
   logic [1:0]  mode_q  [NUM_DEV];
   logic [NCH-1:0] data_pend_q;
   logic [NCH-1:0] cfg_pend_q;
   logic [NUM_DEV-1:0] busy;
   logic [NUM_DEV-1:0] load_req;

   function automatic logic hit(input logic [11:0] base,
                                input int n, input logic [11:0] a);
      hit = (a >= base) && (a < base + 12'(4 * n)) && (a[1:0] == 2'b00);
   endfunction : hit

   logic [2:0] ch_sel;
   assign ch_sel = paddr[4:2];

   // ------------------------------------------------------------------
   // register writes, one generate loop per channel
   // ------------------------------------------------------------------
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      // config, data and correction registers of channel c
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cfg_q[c]  <= dcc_pkg::CFG_RESET;
            data_q[c] <= 16'h0000;
            gain_q[c] <= 16'h0000;
            offs_q[c] <= 16'h0000;
         end else if (wr_en && 32'(ch_sel) == c) begin
            if (hit(dcc_pkg::ADDR_CFG0, NCH, paddr) &&
                pwdata[3:0] <= dcc_pkg::RANGE_LAST)
               cfg_q[c] <= pwdata[5:0];
            if (hit(dcc_pkg::ADDR_DATA0, NCH, paddr))
               data_q[c] <= pwdata[15:0];
            if (hit(dcc_pkg::ADDR_GAIN0, NCH, paddr))
               gain_q[c] <= pwdata[15:0];
            if (hit(dcc_pkg::ADDR_OFFS0, NCH, paddr))
               offs_q[c] <= pwdata[15:0];
         end
      end
   end

   // device mode registers
   for (genvar d = 0; d < NUM_DEV; d++) begin : g_mode
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)
            mode_q[d] <= dcc_pkg::MODE_RESET;
         else if (wr_en && hit(dcc_pkg::ADDR_MODE0, NUM_DEV, paddr) &&
                  32'(paddr[2]) == d)
            mode_q[d] <= pwdata[1:0];
      end
   end

   // ------------------------------------------------------------------
   // correction arithmetic
   // ------------------------------------------------------------------
   // signed arithmetic at 40 bits; unipolar and current codes are
   // lifted to signed by a zero msb so one datapath serves all codings
   function automatic logic [15:0] correct(input logic [15:0] raw,
                                           input logic [15:0] g,
                                           input logic [15:0] o,
                                           input logic        bip);
      logic signed [39:0] v;
      logic signed [39:0] p;
      logic signed [39:0] lo;
      logic signed [39:0] hi;
      v  = bip ? 40'(signed'(raw)) : 40'({1'b0, raw});
      p  = v - ((v * 40'(signed'(g))) >>> dcc_pkg::GAIN_SHIFT);
      p  = p - (40'(signed'(o)) >>> dcc_pkg::OFFS_SHIFT);
      lo = bip ? -40'sd32768 : 40'sd0;
      hi = bip ? 40'sd32767 : 40'sd65535;
      if (p < lo) p = lo;
      if (p > hi) p = hi;
      correct = p[15:0]; // zero corrections give raw back
   endfunction : correct

   // ------------------------------------------------------------------
   // pending tracking and serialisation
   // ------------------------------------------------------------------
   dcc_ser_if sif [NUM_DEV] ();
   logic [2:0] cur_q [NUM_DEV];
   logic       cur_cfg_q [NUM_DEV];
   logic       sent_q [NUM_DEV];
   logic       clr_q [NUM_DEV];

   // pending bits: a write sets, the scheduler clears; set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_pend_q <= '0;
         cfg_pend_q  <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (clr_q[c / 4] && cur_q[c / 4][1:0] == 2'(c % 4)) begin
               if (cur_cfg_q[c / 4]) cfg_pend_q[c]  <= 1'b0;
               else                  data_pend_q[c] <= 1'b0;
            end
            if (wr_en && 32'(ch_sel) == c &&
                hit(dcc_pkg::ADDR_CFG0, NCH, paddr))
               cfg_pend_q[c] <= 1'b1;
            if (wr_en && 32'(ch_sel) == c &&
                hit(dcc_pkg::ADDR_DATA0, NCH, paddr))
               data_pend_q[c] <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // per-device scheduler and load strobe
   // ------------------------------------------------------------------
   logic seq_s1_q;
   logic seq_s2_q;
   logic seq_s3_q;
   logic seq_evt;
   logic [NUM_DEV-1:0] creq;

   // rear line sync, then rising edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_s1_q <= 1'b0;
         seq_s2_q <= 1'b0;
         seq_s3_q <= 1'b0;
      end else begin
         seq_s1_q <= seq_conv_clk;
         seq_s2_q <= seq_s1_q;
         seq_s3_q <= seq_s2_q;
      end
   end
   assign seq_evt = seq_s2_q && !seq_s3_q;
   assign creq = (wr_en && paddr == dcc_pkg::ADDR_GCTRL) ?
                 pwdata[NUM_DEV-1:0] : '0;

   for (genvar d = 0; d < NUM_DEV; d++) begin : g_dev
      logic [3:0] dp;
      logic [3:0] cp;
      logic       any;
      logic [2:0] pick;
      logic       pick_cfg;
      logic       imm_arm_q;
      logic [2:0] ld_cnt_q;
      assign dp = data_pend_q[4*d +: 4];
      assign cp = cfg_pend_q[4*d +: 4];
      assign any = |dp || |cp;

      // lowest pending channel, configuration first
      always_comb begin
         pick     = 3'h0;
         pick_cfg = 1'b0;
         for (int i = 3; i >= 0; i--) begin
            if (dp[i]) begin
               pick = 3'(i);
               pick_cfg = 1'b0;
            end
         end
         for (int i = 3; i >= 0; i--) begin
            if (cp[i]) begin
               pick = 3'(i);
               pick_cfg = 1'b1;
            end
         end
      end

      // launch one word; ready drop means accepted
      assign sif[d].valid = any && !sent_q[d];
      assign sif[d].word  = pick_cfg ?
         {dcc_pkg::KIND_CFG, 3'(pick), 13'h0000,
          cfg_q[4*d + 32'(pick)]} :
         {dcc_pkg::KIND_DATA, 3'(pick), 3'h0,
          correct(data_q[4*d + 32'(pick)], gain_q[4*d + 32'(pick)],
                  offs_q[4*d + 32'(pick)],
                  cfg_q[4*d + 32'(pick)][3:0] >= dcc_pkg::RANGE_BIP_LO &&
                  cfg_q[4*d + 32'(pick)][3:0] <= dcc_pkg::RANGE_BIP_HI)};

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sent_q[d]    <= 1'b0;
            cur_q[d]     <= 3'h0;
            cur_cfg_q[d] <= 1'b0;
         end else if (sif[d].valid && sif[d].ready) begin
            sent_q[d]    <= 1'b1; // one word in flight
            cur_q[d]     <= pick;
            cur_cfg_q[d] <= pick_cfg;
         end else if (sent_q[d] && sif[d].ready) begin
            sent_q[d] <= 1'b0;
         end
      end

      // one-cycle pulse after launch; clearing only then keeps a
      // write that lands during the shift pending
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)
            clr_q[d] <= 1'b0;
         else
            clr_q[d] <= sif[d].valid && sif[d].ready;
      end

      // busy from first pending write to last completed shift
      assign busy[d] = any || sent_q[d] || !sif[d].ready;

      // immediate mode arms on a data transfer, fires once idle
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)
            imm_arm_q <= 1'b0;
         else if (sent_q[d] && sif[d].ready && !cur_cfg_q[d])
            imm_arm_q <= 1'b1;
         else if (load_req[d] || mode_q[d] != 2'b00)
            imm_arm_q <= 1'b0; // no stale arm after a mode change
      end

      assign load_req[d] =
         (!mode_q[d][0] && !mode_q[d][1] && imm_arm_q && !busy[d]) ||
         (!mode_q[d][0] &&  mode_q[d][1] && creq[d]) ||
         ( mode_q[d][0] && seq_evt);

      // low pulse of fixed width
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)
            ld_cnt_q <= 3'h0;
         else if (load_req[d])
            ld_cnt_q <= 3'(dcc_pkg::LOAD_CYCLES);
         else if (ld_cnt_q != 3'h0)
            ld_cnt_q <= ld_cnt_q - 3'h1;
      end
      assign converter_load_strobe_n[d] = (ld_cnt_q == 3'h0);

      dcc_serializer u_ser (
         .pclk     (pclk),
         .presetn  (presetn),
         .req      (sif[d]),
         .sclk_q   (dac_sclk[d]),
         .sdo_q    (dac_sdo[d]),
         .sync_n_q (dac_sync_n[d])
      );

      AST_IMM_AFTER_IDLE: assert property (@(posedge pclk)
         disable iff (!presetn)
         $fell(converter_load_strobe_n[d]) && mode_q[d] == 2'b00
         |-> $past(!busy[d])) else $error("load while busy");
      AST_CTRL_REQ: assert property (@(posedge pclk)
         disable iff (!presetn)
         mode_q[d] == 2'b10 && creq[d]
         |=> !converter_load_strobe_n[d]) else $error("no load");
      AST_SEQ_EVT: assert property (@(posedge pclk)
         disable iff (!presetn)
         mode_q[d][0] && seq_evt
         |=> !converter_load_strobe_n[d]) else $error("seq miss");
      AST_STROBE_W: assert property (@(posedge pclk)
         disable iff (!presetn)
         $fell(converter_load_strobe_n[d]) && !load_req[d]
         |-> !converter_load_strobe_n[d] [*2]) else $error("width");
      AST_BUSY_SEND: assert property (@(posedge pclk)
         disable iff (!presetn)
         !dac_sync_n[d] |-> busy[d]) else $error("idle busy");
   end

   AST_RESET_OFF: assert property (@(posedge pclk)
      $rose(presetn) |-> cfg_q[0] == 6'h00 && mode_q[0] == 2'b00)
      else $error("reset state");
   AST_PEND_SET: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && hit(dcc_pkg::ADDR_DATA0, NCH, paddr) |=> busy[ch_sel[2]])
      else $error("no busy");
   AST_ZERO_CORR: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |-> correct(data_q[0], 16'h0000, 16'h0000, 1'b0) == data_q[0])
      else $error("corr");

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   always_comb begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      if (paddr == dcc_pkg::ADDR_GCTRL)
         prdata = 32'h0000_0000; // request bits self clear
      else if (paddr == dcc_pkg::ADDR_GSTAT)
         prdata = 32'(busy);
      else if (hit(dcc_pkg::ADDR_MODE0, NUM_DEV, paddr))
         prdata = 32'(mode_q[paddr[2]]);
      else if (hit(dcc_pkg::ADDR_CFG0, NCH, paddr))
         prdata = 32'(cfg_q[ch_sel]);
      else if (hit(dcc_pkg::ADDR_DATA0, NCH, paddr))
         prdata = 32'(data_q[ch_sel]);
      else if (hit(dcc_pkg::ADDR_GAIN0, NCH, paddr))
         prdata = 32'(gain_q[ch_sel]);
      else if (hit(dcc_pkg::ADDR_OFFS0, NCH, paddr))
         prdata = 32'(offs_q[ch_sel]);
      else
         pslverr = psel && penable; // unmapped
   end
endmodule : dcc_top

// ===== test/dcc_conv_model.sv
// behavioural quad converter: decodes serial words, counts load pulses
module dcc_conv_model (
   input  wire logic        sclk,
   input  wire logic        sdo,
   input  wire logic        sync_n,
   input  wire logic        load_n,
   output logic      [23:0] last_word,
   output int               n_words,
   output int               n_loads
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] sh;
   int          cnt;
   initial begin
      sh = 24'h000000;
      cnt = 0;
      last_word = 24'h000000;
      n_words = 0;
      n_loads = 0;
   end
   // one bit per rising serial clock, msb first; sdo moves on the fall
   always @(posedge sclk) begin
      if (sync_n === 1'b0) begin
         sh = {sh[22:0], sdo};
         cnt++;
      end
   end
   // frame end: short frames are dropped, as a real part would
   always @(posedge sync_n) begin
      if (cnt == 24) begin
         last_word = sh;
         n_words++;
      end
      cnt = 0;
   end
   // each low pulse updates the outputs
   always @(negedge load_n) begin
      n_loads++;
   end
endmodule : dcc_conv_model

// ===== test/test_dcc_top.sv
module test_dcc_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int ND = 2;
   logic          pclk, presetn, psel, penable, pwrite, seq_conv_clk;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd, rd_s;
   logic          pready, pslverr, er, er_s, rdy_s;
   logic [ND-1:0] sclk, sdo, sync_n, load_n;
   logic [23:0]   lw [ND];
   int            nw [ND];
   int            nl [ND];
   int            fails = 0;
   int            n_tests = 0;
   int            cyc = 0;
   event          smp;

   dcc_top #(.NUM_DEV(ND)) dcc_top_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .seq_conv_clk(seq_conv_clk), .dac_sclk(sclk),
      .dac_sdo(sdo), .dac_sync_n(sync_n),
      .converter_load_strobe_n(load_n));

   for (genvar d = 0; d < ND; d++) begin : g_dev
      dcc_conv_model dcc_conv_model_i (.sclk(sclk[d]), .sdo(sdo[d]),
         .sync_n(sync_n[d]), .load_n(load_n[d]), .last_word(lw[d]),
         .n_words(nw[d]), .n_loads(nl[d]));
   end

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // pre-edge snapshot of the answer; blocking so design updates miss it
   always @(posedge pclk) begin
      rdy_s = pready;
      rd_s = prdata;
      er_s = pslverr;
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report;
      end
      -> smp;
   end
   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [11:0] ra(logic [11:0] b, int c);
      return b + 12'(4 * c);
   endfunction : ra

   // one apb transfer; held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(smp);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(smp);
      penable <= 1'b1;
      do begin
         @(smp);
      end while (rdy_s !== 1'b1);
      rd = rd_s;
      er = er_s;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // poll status until both busy flags drop, then let a strobe finish
   task automatic idle;
      int k;
      k = 0;
      do begin
         apb(1'b0, dcc_pkg::ADDR_GSTAT, 32'h0);
         k++;
      end while (rd[1:0] !== 2'b00 && k < 200);
      chk({31'h0, k < 200}, 32'h1);
      repeat (6) @(posedge pclk);
   endtask : idle

   task automatic wr(input logic [11:0] b, input int c, input logic [31:0] v);
      apb(1'b1, ra(b, c), v);
      idle;
   endtask : wr

   // data write: busy must show, then payload and load count are judged
   task automatic xfer(input int c, input logic [15:0] d,
                       input logic [15:0] e, input int ld);
      int dv;
      int l0;
      dv = c / 4;
      l0 = nl[dv];
      apb(1'b1, ra(dcc_pkg::ADDR_DATA0, c), {16'h0000, d});
      apb(1'b0, dcc_pkg::ADDR_GSTAT, 32'h0);
      chk({31'h0, rd[dv]}, 32'h1);
      idle;
      chk({16'h0000, lw[dv][15:0]}, {16'h0000, e});
      chk(32'(nl[dv] - l0), 32'(ld));
   endtask : xfer
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_reset;
      chk({30'h0, load_n}, 32'h3);
      apb(1'b0, ra(dcc_pkg::ADDR_MODE0, 1), 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ra(dcc_pkg::ADDR_CFG0, 7), 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h400, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("reset test done");
   endtask : t_reset

   task automatic t_ranges;
      for (int r = 0; r <= 10; r++) begin
         wr(dcc_pkg::ADDR_CFG0, 1, 32'h10 | 32'(r));
         apb(1'b0, ra(dcc_pkg::ADDR_CFG0, 1), 32'h0);
         chk(rd, 32'h10 | 32'(r));
      end
      wr(dcc_pkg::ADDR_CFG0, 1, 32'h1B);
      apb(1'b0, ra(dcc_pkg::ADDR_CFG0, 1), 32'h0);
      chk(rd, 32'h1A);
      $display("range test done");
   endtask : t_ranges

   task automatic t_immediate;
      wr(dcc_pkg::ADDR_CFG0, 0, 32'h10);
      xfer(0, 16'h0001, 16'h0001, 1);
      xfer(0, 16'h0000, 16'h0000, 1);
      wr(dcc_pkg::ADDR_CFG0, 0, 32'h30);
      xfer(5, 16'hFFFF, 16'hFFFF, 1);
      $display("immediate test done");
   endtask : t_immediate

   // exact-figure corrections only, so rounding never decides
   task automatic t_correct;
      wr(dcc_pkg::ADDR_CFG0, 2, 32'h10);
      wr(dcc_pkg::ADDR_GAIN0, 2, 32'h8);
      xfer(2, 16'h8000, 16'h7FFF, 1);
      wr(dcc_pkg::ADDR_GAIN0, 2, 32'h0);
      wr(dcc_pkg::ADDR_OFFS0, 2, 32'h4);
      xfer(2, 16'h0000, 16'h0000, 1);
      xfer(2, 16'h0005, 16'h0004, 1);
      wr(dcc_pkg::ADDR_OFFS0, 2, 32'hFFFC);
      xfer(2, 16'hFFFF, 16'hFFFF, 1);
      wr(dcc_pkg::ADDR_CFG0, 2, 32'h14);
      xfer(2, 16'h7FFF, 16'h7FFF, 1);
      wr(dcc_pkg::ADDR_OFFS0, 2, 32'h4);
      xfer(2, 16'h8000, 16'h8000, 1);
      wr(dcc_pkg::ADDR_OFFS0, 2, 32'h0);
      wr(dcc_pkg::ADDR_GAIN0, 2, 32'h10);
      xfer(2, 16'hC000, 16'hC001, 1);
      wr(dcc_pkg::ADDR_CFG0, 2, 32'h18);
      xfer(2, 16'h8000, 16'h7FFE, 1);
      wr(dcc_pkg::ADDR_GAIN0, 2, 32'h0);
      $display("correction test done");
   endtask : t_correct

   task automatic t_burst;
      int l0;
      int w0;
      l0 = nl[1];
      w0 = nw[1];
      for (int c = 4; c < 8; c++) begin
         apb(1'b1, ra(dcc_pkg::ADDR_DATA0, c), 32'h1000 + 32'(c));
      end
      chk(32'(nl[1] - l0), 32'h0);
      apb(1'b0, dcc_pkg::ADDR_GSTAT, 32'h0);
      chk({31'h0, rd[1]}, 32'h1);
      idle;
      chk(32'(nw[1] - w0), 32'h4);
      chk({8'h00, lw[1]} & 32'hFFFF, 32'h1007);
      chk(32'(nl[1] - l0), 32'h1);
      $display("burst test done");
   endtask : t_burst

   task automatic t_ctrl;
      int l0;
      wr(dcc_pkg::ADDR_MODE0, 0, 32'h2);
      l0 = nl[0];
      wr(dcc_pkg::ADDR_DATA0, 3, 32'h1234);
      chk({8'h00, lw[0]} & 32'hFFFF, 32'h1234);
      chk(32'(nl[0] - l0), 32'h0);
      apb(1'b1, dcc_pkg::ADDR_GCTRL, 32'h1);
      repeat (6) @(posedge pclk);
      chk(32'(nl[0] - l0), 32'h1);
      wr(dcc_pkg::ADDR_MODE0, 0, 32'h0);
      chk(32'(nl[0] - l0), 32'h1);
      $display("controlled test done");
   endtask : t_ctrl

   task automatic t_seq;
      int l0;
      int l1;
      wr(dcc_pkg::ADDR_MODE0, 0, 32'h1);
      l0 = nl[0];
      l1 = nl[1];
      @(posedge pclk);
      seq_conv_clk <= 1'b1;
      repeat (3) @(posedge pclk);
      seq_conv_clk <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(32'(nl[0] - l0), 32'h1);
      chk(32'(nl[1] - l1), 32'h0);
      wr(dcc_pkg::ADDR_MODE0, 0, 32'h0);
      $display("sequencer test done");
   endtask : t_seq

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      seq_conv_clk = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_ranges;
      t_immediate;
      t_correct;
      t_burst;
      t_ctrl;
      t_seq;
      final_report;
   end
endmodule : test_dcc_top
